// *** rtl/fssg_pkg.sv ***
// Package for the flash security shield guard: word layouts, defaults and types
package fssg_pkg;

   // ----------------------------------------------------------------------
   // Security and boot-swap word layout
   // ----------------------------------------------------------------------
   localparam int unsigned SEC_WRITE_BIT   = 12;
   localparam int unsigned SEC_ERASE_BIT   = 10;
   localparam int unsigned SEC_BOOT_BIT    = 9;
   localparam int unsigned SEC_BSEL_BIT    = 8;
   localparam int unsigned SEC_IFACE_BIT   = 2;
   localparam int unsigned SEC_IDDIS_BIT   = 0;
   localparam logic [31:0] SEC_FLAG_MASK   = 32'h0000_1705;
   localparam logic [31:0] SEC_RESET_VAL   = 32'hFFFF_FFFF;

   // ----------------------------------------------------------------------
   // Window setting word layout
   // ----------------------------------------------------------------------
   localparam int unsigned WIN_SEL_BIT     = 31;
   localparam int unsigned WIN_PERMIT_BIT  = 15;
   localparam int unsigned WIN_END_LSB     = 16;
   localparam int unsigned WIN_START_LSB   = 0;
   localparam int unsigned BLK_W           = 9;
   localparam logic [31:0] WIN_FIXED_MASK  = 32'h7E00_7E00;
   localparam logic [31:0] WIN_RESET_VAL   = 32'hFFFF_FE00;

   // ----------------------------------------------------------------------
   // Boot area blocks (protected boot cluster)
   // ----------------------------------------------------------------------
   localparam logic [8:0]  BOOT_LAST_BLK   = 9'h003;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      FSSG_CMD_WRITE,
      FSSG_CMD_ERASE,
      FSSG_CMD_SEC_WR,
      FSSG_CMD_WIN_WR,
      FSSG_CMD_CHIP_ERASE,
      FSSG_CMD_SEC_RELEASE
   } fssg_cmd_e;

   typedef struct packed {
      fssg_cmd_e   cmd;
      logic        serial;     // 1: serial programming, 0: self-programming
      logic        data_flash; // Target is data flash
      logic [8:0]  block;
   } fssg_req_s;

   typedef struct packed {
      logic serial_write_permit;
      logic serial_erase_permit;
      logic boot_rewrite_permit;
      logic boot_cluster_select;
      logic programming_interface_permit;
      logic id_auth_disable;
   } fssg_flags_s;

endpackage : fssg_pkg

// *** rtl/fssg_guard.sv ***
// Flash security shield guard: security word, shield window and request checks
//
// Contract
// - Security word is 32 bits from write-data high/low; non-flag bits forced 1.
// - Serial write permit 0 rejects serial-mode writes.
// - Serial erase permit 0 rejects serial-mode block erases.
// - Boot rewrite permit 0 blocks boot area rewrite and boot swap.
// - With temporary swap mode 0, boot select 0 picks cluster 1, 1 cluster 0.
// - Interface permit 0 refuses serial mode, programmer and debugger.
// - ID auth disable 0 requires ID authentication for serial connection.
// - All flags reset to 1: permits on, cluster 0, no ID check.
// - Serial write permit returns to 1 only via chip erase or release.
// - Chip erase and release refused if erase or boot permit is 0.
// - Interface off or ID auth on blocks serial restore of write permit.
// - Erase, boot, interface and ID flags never return from 0 to 1.
// - Shield blocks write and erase only in self-programming.
// - Shield area is inside or outside the window range.
// - Window is start block and end equal to last block plus one.
// - Window settable from serial and self-programming.
// - Boot rewrite prohibition wins over the window setting.
// - Window applies only to code flash, never data flash.
// - Area select bit 31: 0 inside, 1 outside, default outside.
// - End field bits 24..16, start field bits 8..0.
// - Window change permit bit 15 at 0 refuses window changes.
`timescale 1ns/100ps

module fssg_guard
   import fssg_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        arst_n_i,
   // Request from the flash sequencer
   input  wire logic        req_valid_i,
   input  wire fssg_req_s   req_i,
   input  wire logic [15:0] write_data_high_i,
   input  wire logic [15:0] write_data_low_i,
   input  wire logic        flash_all_erased_i,
   input  wire logic        temporary_swap_mode_i,
   input  wire logic        swap_request_i,
   input  wire logic        err_clear_i,
   // Decision back to the sequencer
   output logic             grant_o,
   output logic             refuse_o,
   output logic             error_o,
   output logic             swap_grant_o,
   // Evaluated security state
   output fssg_flags_s      flags_o,
   output logic             boot_from_cluster1_o,
   output logic             serial_entry_permit_o,
   output logic             id_auth_required_o,
   output logic [31:0]      sec_word_o,
   output logic [31:0]      win_word_o
);

   // ----------------------------------------------------------------------
   // Reset synchroniser
   // ----------------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n_q;

   // Two-stage release of the asynchronous reset
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------------
   // Stored words
   // ----------------------------------------------------------------------
   logic [31:0] sec_q;
   logic [31:0] sec_d;
   logic [31:0] win_q;
   logic [31:0] win_d;
   logic        err_q;
   logic        err_d;
   logic        grant_q;
   logic        refuse_q;

   // Incoming data word and decoded fields
   wire logic [31:0] wr_word = {write_data_high_i, write_data_low_i};
   wire logic        f_write = sec_q[SEC_WRITE_BIT];
   wire logic        f_erase = sec_q[SEC_ERASE_BIT];
   wire logic        f_boot  = sec_q[SEC_BOOT_BIT];
   wire logic        f_bsel  = sec_q[SEC_BSEL_BIT];
   wire logic        f_iface = sec_q[SEC_IFACE_BIT];
   wire logic        f_iddis = sec_q[SEC_IDDIS_BIT];

   // Window fields
   wire logic        win_outside = win_q[WIN_SEL_BIT];
   wire logic        win_permit  = win_q[WIN_PERMIT_BIT];
   wire logic [8:0]  win_end     = win_q[WIN_END_LSB +: BLK_W];
   wire logic [8:0]  win_start   = win_q[WIN_START_LSB +: BLK_W];

   // ----------------------------------------------------------------------
   // Request classification
   // ----------------------------------------------------------------------
   wire logic is_write   = req_i.cmd == FSSG_CMD_WRITE;
   wire logic is_erase   = req_i.cmd == FSSG_CMD_ERASE;
   wire logic is_sec_wr  = req_i.cmd == FSSG_CMD_SEC_WR;
   wire logic is_win_wr  = req_i.cmd == FSSG_CMD_WIN_WR;
   wire logic is_wipe    = (req_i.cmd == FSSG_CMD_CHIP_ERASE)
                         | (req_i.cmd == FSSG_CMD_SEC_RELEASE);
   wire logic is_rewrite = is_write | is_erase;
   wire logic in_boot    = ~req_i.data_flash & (req_i.block <= BOOT_LAST_BLK);

   // Serial connection is usable only with interface on and no ID demand
   wire logic serial_ok  = f_iface;
   wire logic serial_cmd_ok = serial_ok & f_iddis;

   // Window membership: end is last block plus one, so range is half-open
   wire logic in_window  = (req_i.block >= win_start) & (req_i.block < win_end);
   wire logic in_shield  = win_outside ? ~in_window : in_window;
   wire logic shield_hit = ~req_i.serial & ~req_i.data_flash
                         & in_shield & is_rewrite;

   // Boot area rewrite prohibition takes priority over any window opening
   wire logic boot_hit   = is_rewrite & in_boot & ~f_boot;

   // Serial-mode command checks
   wire logic ser_hit    = req_i.serial & (~serial_cmd_ok
                         | (is_write & ~f_write)
                         | (is_erase & ~f_erase));

   // Wipe commands only serial, only with erase and boot permits, all erased
   wire logic wipe_hit   = is_wipe & (~req_i.serial | ~f_erase | ~f_boot
                         | ~flash_all_erased_i);

   // Window change blocked once its permit is cleared
   wire logic win_hit    = is_win_wr & ~win_permit;

   wire logic refuse_now = ser_hit | shield_hit | boot_hit | wipe_hit | win_hit;
   wire logic accept     = req_valid_i & ~refuse_now;

   // Security word update: non-flags forced 1, permits only sticky toward 0
   wire logic [31:0] sec_wr_val = (wr_word | ~SEC_FLAG_MASK)
                                & (sec_q | ~SEC_FLAG_MASK
                                   | (32'h0000_0001 << SEC_BSEL_BIT));
   // Wipe restores the serial write permit only
   wire logic [31:0] sec_wipe   = sec_q | (32'h0000_0001 << SEC_WRITE_BIT);

   // Window update keeps the fixed bits at one
   wire logic [31:0] win_wr_val = wr_word | WIN_FIXED_MASK;

   // Next-state selection
   always_comb
   begin
      sec_d = sec_q;
      win_d = win_q;
      if (accept & is_sec_wr)
      begin
         sec_d = sec_wr_val;
      end
      else if (accept & is_wipe)
      begin
         sec_d = sec_wipe;
      end
      if (accept & is_win_wr)
      begin
         win_d = win_wr_val;
      end
   end

   // Sticky error: a new refusal wins over a clear in the same cycle
   assign err_d = (req_valid_i & refuse_now) | (err_q & ~err_clear_i);

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         sec_q    <= SEC_RESET_VAL;
         win_q    <= WIN_RESET_VAL;
         err_q    <= 1'b0;
         grant_q  <= 1'b0;
         refuse_q <= 1'b0;
      end
      else
      begin
         sec_q    <= sec_d;
         win_q    <= win_d;
         err_q    <= err_d;
         grant_q  <= accept;
         refuse_q <= req_valid_i & refuse_now;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign grant_o               = grant_q;
   assign refuse_o              = refuse_q;
   assign error_o               = err_q;
   assign swap_grant_o          = swap_request_i & f_boot;
   assign flags_o               = '{serial_write_permit:          f_write,
                                    serial_erase_permit:          f_erase,
                                    boot_rewrite_permit:          f_boot,
                                    boot_cluster_select:          f_bsel,
                                    programming_interface_permit: f_iface,
                                    id_auth_disable:              f_iddis};
   // Cluster 1 boots when select is 0; swap mode leaves it to the swap logic
   assign boot_from_cluster1_o  = ~temporary_swap_mode_i & ~f_bsel;
   assign serial_entry_permit_o = f_iface;
   assign id_auth_required_o    = ~f_iddis;
   assign sec_word_o            = sec_q;
   assign win_word_o            = win_q;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   chk_write_refused: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      req_valid_i && req_i.serial && is_write && !f_write |=> refuse_o && !grant_o)
      else $error("serial write not refused");

   chk_erase_refused: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      req_valid_i && req_i.serial && is_erase && !f_erase |=> refuse_o)
      else $error("serial erase not refused");

   chk_boot_priority: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      req_valid_i && is_rewrite && in_boot && !f_boot |=> refuse_o)
      else $error("boot area rewrite not refused");

   chk_wipe_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      req_valid_i && is_wipe && (!f_erase || !f_boot) |=> refuse_o && $stable(sec_q))
      else $error("wipe not refused");

   chk_flags_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      !sec_q[SEC_ERASE_BIT] |=> !sec_q[SEC_ERASE_BIT] && !$rose(sec_q[SEC_IFACE_BIT]))
      else $error("sticky flag returned to one");

   chk_shield_self: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      req_valid_i && !req_i.serial && !req_i.data_flash && is_rewrite && in_shield
      |=> refuse_o ##0 error_o)
      else $error("shield not enforced");

   chk_data_flash_free: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      req_valid_i && req_i.data_flash && !req_i.serial && is_rewrite |=> !refuse_o)
      else $error("data flash blocked by window");

   chk_window_lock: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      !win_permit |=> $stable(win_q))
      else $error("window changed while locked");

   chk_cluster_pick: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      !temporary_swap_mode_i |-> boot_from_cluster1_o == !sec_q[SEC_BSEL_BIT])
      else $error("boot cluster mismatch");

   chk_error_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      error_o && !err_clear_i |=> error_o)
      else $error("error lost");

   // ----------------------------------------------------------------------
   // Multi-step checks
   // ----------------------------------------------------------------------
   // A request on the strobe
   sequence s_request;
      req_valid_i;
   endsequence

   // Exactly one of the two answer pulses
   sequence s_one_answer;
      grant_o ^ refuse_o;
   endsequence

   // Both stored words untouched since the previous edge
   sequence s_words_kept;
      $stable(sec_q) && $stable(win_q);
   endsequence

   // A self-programming write or erase aimed at code flash
   sequence s_self_code;
      req_valid_i && !req_i.serial && !req_i.data_flash && is_rewrite;
   endsequence

   chk_answer_single: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      s_request |=> s_one_answer)
      else $error("request not answered exactly once");

   chk_idle_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      !req_valid_i |=> !grant_o && !refuse_o)
      else $error("answer without request");

   chk_refuse_keeps: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      req_valid_i && refuse_now |=> refuse_o ##0 s_words_kept ##0 error_o)
      else $error("refused request changed state");

   chk_fill_ones: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      (sec_q | SEC_FLAG_MASK) == 32'hFFFF_FFFF)
      else $error("security word filler bit cleared");

   chk_win_fixed: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      (win_q & WIN_FIXED_MASK) == WIN_FIXED_MASK)
      else $error("window word fixed bit cleared");

   chk_swap_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      !f_boot |-> !swap_grant_o)
      else $error("swap granted while boot rewrite off");

   chk_iface_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      req_valid_i && req_i.serial && !f_iface |=> refuse_o)
      else $error("serial request with interface off");

   chk_id_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      req_valid_i && req_i.serial && !f_iddis |=> refuse_o)
      else $error("serial request without id check");

   chk_write_restore: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      $rose(f_write) |-> $past(accept) && $past(is_wipe))
      else $error("write permit restored outside wipe");

   chk_boot_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      !f_boot |=> !f_boot)
      else $error("boot permit returned to one");

   chk_auth_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      !f_iddis |=> !f_iddis)
      else $error("id check disable returned to one");

   chk_iface_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      !f_iface |=> !f_iface)
      else $error("interface permit returned to one");

   chk_shield_serial: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      req_valid_i && req_i.serial && serial_cmd_ok && is_erase && f_erase && !boot_hit
      |=> grant_o)
      else $error("shield applied to serial erase");

   chk_window_edge: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      s_self_code ##0 (!win_outside && req_i.block == win_end && req_i.block > BOOT_LAST_BLK)
      |=> grant_o)
      else $error("block after window end was shielded");

   chk_window_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      req_valid_i && is_win_wr && win_permit && (!req_i.serial || serial_cmd_ok) |=> grant_o)
      else $error("open window write refused");

   chk_wipe_serial: assert property (@(posedge core_clk_i) disable iff (!rst_n_q)
      req_valid_i && is_wipe && !req_i.serial |=> refuse_o)
      else $error("wipe accepted outside serial mode");

endmodule : fssg_guard

// *** dv/fssg_seq_model.sv ***
// Partner model of the flash sequencer: issues requests and builds data words
`timescale 1ns/100ps

module fssg_seq_model
   import fssg_pkg::*;
(
   // Clock
   input  wire logic   core_clk_i,
   // Answer from the guard
   input  wire logic   grant_i,
   input  wire logic   refuse_i,
   // Request towards the guard
   output logic        req_valid_o,
   output fssg_req_s   req_o,
   output logic [15:0] write_data_high_o,
   output logic [15:0] write_data_low_o
);
   // ----------------------------------------------------------------------
   // Idle request lines
   // ----------------------------------------------------------------------
   initial
   begin
      req_valid_o = 1'b0;
      req_o = '0;
      {write_data_high_o, write_data_low_o} = 32'h0000_0000;
   end

   // Security word: boot select as given, cleared flags 0, all else 1
   function automatic logic [31:0] sec(input logic bsel, input logic [31:0] clr);
      logic [31:0] w;
      w = 32'hFFFF_FFFF & ~clr;
      w[SEC_BSEL_BIT] = bsel;
      return w;
   endfunction : sec

   // Window word: fixed positions written as 1, end is last block plus one
   function automatic logic [31:0] win(input logic sel, input logic prm,
                                       input logic [8:0] fin, input logic [8:0] st);
      return {sel, 6'h3F, fin, prm, 6'h3F, st};
   endfunction : win

   // One request strobe; the answer stands in the following cycle
   task automatic issue(input fssg_cmd_e cmd, input logic ser, input logic df,
                        input logic [8:0] blk, input logic [31:0] data,
                        output logic g, output logic r);
      @(negedge core_clk_i);
      req_valid_o = 1'b1;
      req_o = '{cmd: cmd, serial: ser, data_flash: df, block: blk};
      {write_data_high_o, write_data_low_o} = data;
      @(negedge core_clk_i);
      g = grant_i;
      r = refuse_i;
      req_valid_o = 1'b0;
      {write_data_high_o, write_data_low_o} = ~data; // Released bus shows no stale value
   endtask : issue
endmodule : fssg_seq_model

// *** dv/tb_top.sv ***
// Self-checking testbench for the flash security shield guard
`timescale 1ns/100ps

module tb_top;
   import fssg_pkg::*;
   logic        core_clk_i, arst_n_i, req_valid_i, flash_all_erased_i;
   logic        temporary_swap_mode_i, swap_request_i, err_clear_i;
   logic        grant_o, refuse_o, error_o, swap_grant_o;
   logic        boot_from_cluster1_o, serial_entry_permit_o, id_auth_required_o;
   fssg_req_s   req_i;
   fssg_flags_s flags_o;
   logic [15:0] write_data_high_i, write_data_low_i;
   logic [31:0] sec_word_o, win_word_o;
   int          n_errors, n_compared, i;

   fssg_guard u_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
      .req_i(req_i), .write_data_high_i(write_data_high_i), .write_data_low_i(write_data_low_i),
      .flash_all_erased_i(flash_all_erased_i), .temporary_swap_mode_i(temporary_swap_mode_i),
      .swap_request_i(swap_request_i), .err_clear_i(err_clear_i), .grant_o(grant_o),
      .refuse_o(refuse_o), .error_o(error_o), .swap_grant_o(swap_grant_o), .flags_o(flags_o),
      .boot_from_cluster1_o(boot_from_cluster1_o), .serial_entry_permit_o(serial_entry_permit_o),
      .id_auth_required_o(id_auth_required_o), .sec_word_o(sec_word_o), .win_word_o(win_word_o));

   fssg_seq_model u_seq (.core_clk_i(core_clk_i), .grant_i(grant_o), .refuse_i(refuse_o),
      .req_valid_o(req_valid_i), .req_o(req_i), .write_data_high_o(write_data_high_i),
      .write_data_low_o(write_data_low_i));

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Issue a request and compare grant and refuse against the expectation
   task automatic op(input fssg_cmd_e c, input logic s, input logic d, input logic [8:0] b,
                     input logic [31:0] w, input logic eg);
      logic g, r;
      u_seq.issue(c, s, d, b, w, g, r);
      check({30'h0, g, r}, {30'h0, eg, ~eg});
   endtask : op

   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset();
      check(sec_word_o, SEC_RESET_VAL);
      check(win_word_o, 32'hFFFF_FE00);
      check({26'h0, flags_o}, 32'h0000_003F);
      check({29'h0, id_auth_required_o, boot_from_cluster1_o, serial_entry_permit_o}, 32'h1);
   endtask : t_reset

   task automatic t_window();
      op(FSSG_CMD_WIN_WR, 0, 0, 0, u_seq.win(1, 1, 5, 4), 1);
      check(win_word_o, 32'hFE05_FE04);
      op(FSSG_CMD_WRITE, 0, 0, 4, 0, 1);
      op(FSSG_CMD_WRITE, 0, 0, 5, 0, 0);
      check({31'h0, error_o}, 32'h1);
      op(FSSG_CMD_ERASE, 1, 0, 5, 0, 1);
      op(FSSG_CMD_WRITE, 0, 1, 5, 0, 1);
      @(negedge core_clk_i) err_clear_i = 1'b1;
      @(negedge core_clk_i) err_clear_i = 1'b0;
      check({31'h0, error_o}, 32'h0);
      op(FSSG_CMD_WIN_WR, 1, 0, 0, u_seq.win(0, 1, 7, 4), 1);
      op(FSSG_CMD_ERASE, 0, 0, 4, 0, 0);
      op(FSSG_CMD_WRITE, 0, 0, 6, 0, 0);
      op(FSSG_CMD_WRITE, 0, 0, 7, 0, 1);
      op(FSSG_CMD_WIN_WR, 0, 0, 0, u_seq.win(0, 0, 7, 4), 1);
      op(FSSG_CMD_WIN_WR, 1, 0, 0, u_seq.win(1, 1, 9'h1FF, 0), 0);
      check(win_word_o, 32'h7E07_7E04);
   endtask : t_window

   task automatic t_boot_select();
      op(FSSG_CMD_SEC_WR, 0, 0, 0, u_seq.sec(0, 0), 1);
      check(sec_word_o, 32'hFFFF_FEFF);
      check({31'h0, boot_from_cluster1_o}, 32'h1);
      @(negedge core_clk_i) temporary_swap_mode_i = 1'b1;
      @(negedge core_clk_i) check({31'h0, boot_from_cluster1_o}, 32'h0);
      temporary_swap_mode_i = 1'b0;
      op(FSSG_CMD_SEC_WR, 0, 0, 0, u_seq.sec(1, 0), 1);
      check({31'h0, boot_from_cluster1_o}, 32'h0);
   endtask : t_boot_select

   task automatic t_write_permit();
      for (i = 0; i < 2; i++)
      begin
         op(FSSG_CMD_SEC_WR, 1, 0, 0, u_seq.sec(1, 32'h1000), 1);
         op(FSSG_CMD_WRITE, 1, 0, 20, 0, 0);
         op(FSSG_CMD_WRITE, 0, 0, 20, 0, 1);
         op(FSSG_CMD_SEC_WR, 1, 0, 0, SEC_RESET_VAL, 1);
         check(sec_word_o, 32'hFFFF_EFFF);
         flash_all_erased_i = 1'b0;
         op(i ? FSSG_CMD_SEC_RELEASE : FSSG_CMD_CHIP_ERASE, 1, 0, 0, 0, 0);
         flash_all_erased_i = 1'b1;
         op(i ? FSSG_CMD_SEC_RELEASE : FSSG_CMD_CHIP_ERASE, 0, 0, 0, 0, 0);
         op(i ? FSSG_CMD_SEC_RELEASE : FSSG_CMD_CHIP_ERASE, 1, 0, 0, 0, 1);
         check(sec_word_o, SEC_RESET_VAL);
      end
   endtask : t_write_permit

   task automatic t_erase_boot();
      swap_request_i = 1'b1;
      @(negedge core_clk_i) check({31'h0, swap_grant_o}, 32'h1);
      op(FSSG_CMD_SEC_WR, 0, 0, 0, u_seq.sec(1, 32'h0400), 1);
      op(FSSG_CMD_ERASE, 1, 0, 20, 0, 0);
      op(FSSG_CMD_WRITE, 1, 0, 20, 0, 1);
      op(FSSG_CMD_CHIP_ERASE, 1, 0, 0, 0, 0);
      op(FSSG_CMD_SEC_WR, 0, 0, 0, SEC_RESET_VAL, 1);
      check(sec_word_o, 32'hFFFF_FBFF);
      op(FSSG_CMD_SEC_WR, 0, 0, 0, u_seq.sec(1, 32'h0600), 1);
      check({31'h0, swap_grant_o}, 32'h0);
      op(FSSG_CMD_WRITE, 0, 0, 3, 0, 0);
      op(FSSG_CMD_WRITE, 1, 0, 3, 0, 0);
      op(FSSG_CMD_WRITE, 0, 0, 20, 0, 1);
      op(FSSG_CMD_SEC_RELEASE, 1, 0, 0, 0, 0);
   endtask : t_erase_boot

   task automatic t_lock();
      op(FSSG_CMD_SEC_WR, 0, 0, 0, u_seq.sec(1, 32'h0001), 1);
      check({31'h0, id_auth_required_o}, 32'h1);
      op(FSSG_CMD_WRITE, 1, 0, 20, 0, 0);
      op(FSSG_CMD_SEC_WR, 0, 0, 0, u_seq.sec(1, 32'h0004), 1);
      check({31'h0, serial_entry_permit_o}, 32'h0);
      op(FSSG_CMD_ERASE, 1, 0, 20, 0, 0);
      op(FSSG_CMD_SEC_WR, 0, 0, 0, SEC_RESET_VAL, 1);
      check(sec_word_o, 32'hFFFF_F9FA);
      check({26'h0, flags_o}, 32'h0000_0024);
   endtask : t_lock

   // ----------------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      n_errors++;
      final_report();
   end

   initial
   begin
      n_errors = 0;
      n_compared = 0;
      arst_n_i = 1'b0;
      flash_all_erased_i = 1'b1;
      temporary_swap_mode_i = 1'b0;
      swap_request_i = 1'b0;
      err_clear_i = 1'b0;
      repeat (8) @(negedge core_clk_i);
      t_reset();
      arst_n_i = 1'b1;
      repeat (4) @(negedge core_clk_i);
      t_window();
      t_boot_select();
      t_write_permit();
      t_erase_boot();
      t_lock();
      final_report();
   end
endmodule : tb_top
